// ---- inc/sslc_link_if.sv ----
// Interface joining the controller end and the switch device end
`timescale 1ns/1ps
`default_nettype none
interface sslc_link_if;
  logic shiftClock;    // Serial shift clock from the controller
  logic serialIn;      // Serial data into the device
  logic chainOut;      // Last shift stage out of the device
  logic latchHoldN;    // latch_hold_n, low is transparent
  logic forceAllOff;   // force_all_off, high turns every switch off
  modport controller (output shiftClock, output serialIn, output latchHoldN,
                      output forceAllOff, input chainOut);
  modport device (input shiftClock, input serialIn, input latchHoldN,
                  input forceAllOff, output chainOut);
endinterface
`default_nettype wire

// ---- inc/sslc_pkg.sv ----
// Package of constants for the serial switch latch control link
package sslc_pkg;
  localparam int SSLC_CHANNELS = 16;                       // Shift register length
  localparam logic [15:0] SSLC_SWITCH_RESET = 16'h0000;    // All switches off
  localparam logic [15:0] SSLC_SHIFT_RESET  = 16'h0000;
  localparam int SSLC_CLK_NS = 4;                          // Local clock period
  localparam int SSLC_SHIFT_MAX_MHZ = 72;                  // Fastest link clock
  localparam int SSLC_LATCH_PULSE_MIN_NS = 12;             // latch_pulse_min
  localparam int SSLC_FORCE_OFF_PULSE_MIN_NS = 55;         // force_off_pulse_min
  localparam int SSLC_POWERUP_WAIT_US = 500;
  // Least times round up to whole cycles
  localparam int SSLC_LATCH_PULSE_CYC =
    (SSLC_LATCH_PULSE_MIN_NS + SSLC_CLK_NS - 1) / SSLC_CLK_NS;
  localparam int SSLC_FORCE_OFF_PULSE_CYC =
    (SSLC_FORCE_OFF_PULSE_MIN_NS + SSLC_CLK_NS - 1) / SSLC_CLK_NS;
  localparam int SSLC_POWERUP_WAIT_CYC =
    (SSLC_POWERUP_WAIT_US * 1000 + SSLC_CLK_NS - 1) / SSLC_CLK_NS;
  // Half period of the generated link clock: 4 cycles gives 31.25 MHz, under the limit
  localparam int SSLC_HALF_PERIOD_CYC = 4;
  localparam int SSLC_MIN_HALF_CYC =
    (1000 + 2 * SSLC_SHIFT_MAX_MHZ * SSLC_CLK_NS - 1) / (2 * SSLC_SHIFT_MAX_MHZ * SSLC_CLK_NS);
endpackage

// ---- logic/sslc_controller.sv ----
// Controller end: writes a word over the link and pulses the latch
`timescale 1ns/1ps
`default_nettype none
module sslc_controller
  import sslc_pkg::*;
#(
  parameter int CHANNELS  = SSLC_CHANNELS,
  parameter int DEVICES   = 1,
  parameter int WAIT_CYC  = SSLC_POWERUP_WAIT_CYC,
  parameter int HALF_CYC  = SSLC_HALF_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // User request
  input  wire logic                        writeValid,
  input  wire logic [CHANNELS*DEVICES-1:0] writeWord,
  input  wire logic                        clearRequest,
  output logic                             writeReady,
  // Link pins
  sslc_link_if.controller                  link
);
  localparam int BITS = CHANNELS * DEVICES;

  typedef enum logic [3:0] {
    SSLC_WAIT  = 4'h1,
    SSLC_IDLE  = 4'h2,
    SSLC_SHIFT = 4'h4,
    SSLC_LATCH = 4'h8
  } sslc_ctl_mode_t;

  typedef struct packed {
    sslc_ctl_mode_t  mode;
    logic [31:0]     count;
    logic [31:0]     bitCount;
    logic [BITS-1:0] word;
    logic            sclk;
    logic            sdata;
    logic            holdN;
    logic            off;
    logic [31:0]     offCount;
    logic            ready;
  } sslc_ctl_state_t;

  sslc_ctl_state_t state_r;
  sslc_ctl_state_t state_nxt;

  // Sequencer: wait, shift 16N bits with hold high, pulse hold low
  always_comb begin
    state_nxt = state_r;
    state_nxt.ready = 1'b0;
    // Clear held high for at least its least width
    if (clearRequest) begin
      state_nxt.off = 1'b1;
      state_nxt.offCount = 32'(SSLC_FORCE_OFF_PULSE_CYC);
    end else if (state_r.offCount != 32'h0) begin
      state_nxt.offCount = state_r.offCount - 32'h1;
    end else begin
      state_nxt.off = 1'b0;
    end
    case (state_r.mode)
      SSLC_WAIT: begin
        if (state_r.count >= 32'(WAIT_CYC)) begin
          state_nxt.mode = SSLC_IDLE;
          state_nxt.ready = 1'b1;
        end else begin
          state_nxt.count = state_r.count + 32'h1;
        end
      end
      SSLC_IDLE: begin
        state_nxt.ready = 1'b1;
        if (writeValid && state_r.ready) begin
          state_nxt.ready = 1'b0;
          state_nxt.mode = SSLC_SHIFT;
          state_nxt.word = writeWord;
          state_nxt.bitCount = 32'h0;
          state_nxt.count = 32'h0;
          state_nxt.sclk = 1'b0;
          state_nxt.sdata = writeWord[BITS-1];
        end
      end
      SSLC_SHIFT: begin
        // Half periods of HALF_CYC keep the rate under the limit
        if (state_r.count + 32'h1 >= 32'(HALF_CYC)) begin
          state_nxt.count = 32'h0;
          state_nxt.sclk = !state_r.sclk;
          if (state_r.sclk) begin
            // Falling edge: present next bit, or finish
            if (state_r.bitCount + 32'h1 >= 32'(BITS)) begin
              state_nxt.mode = SSLC_LATCH;
              state_nxt.holdN = 1'b0;
              state_nxt.sclk = 1'b0;
            end else begin
              state_nxt.word = {state_r.word[BITS-2:0], 1'b0};
              state_nxt.sdata = state_r.word[BITS-2];
              state_nxt.bitCount = state_r.bitCount + 32'h1;
            end
          end
        end else begin
          state_nxt.count = state_r.count + 32'h1;
        end
      end
      SSLC_LATCH: begin
        // Low pulse held long enough, then back high
        if (state_r.count + 32'h1 >= 32'(SSLC_LATCH_PULSE_CYC)) begin
          state_nxt.holdN = 1'b1;
          state_nxt.mode = SSLC_IDLE;
          state_nxt.count = 32'h0;
        end else begin
          state_nxt.count = state_r.count + 32'h1;
        end
      end
      default: begin
        state_nxt.mode = SSLC_WAIT;
      end
    endcase
  end

  // State register; hold starts high so nothing updates before a write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
      state_r.mode <= SSLC_WAIT;
      state_r.holdN <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign writeReady = state_r.ready;
  assign link.shiftClock = state_r.sclk;
  assign link.serialIn = state_r.sdata;
  assign link.latchHoldN = state_r.holdN;
  assign link.forceAllOff = state_r.off;

endmodule
`default_nettype wire

// ---- logic/sslc_device.sv ----
// Switch device end: shift register, latch, clear and chain output
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sixteen-bit shift register, one bit per channel
// - Word arrives MSB first, ends in MSB
// - Link clock never above 72 MHz
// - Latch hold rising edge freezes switch states
// - Hold high: shifting continues, switches unchanged
// - Hold low: register flows straight to switches
// - Chain out is last stage, sixteen clocks delay
// - Chain shares clock and latch hold
// - Latch low pulse at least 12 ns
// - Clear high turns all off; 55 ns
// - After clear, switches follow latch again
// - Data sampled on rising link clock edge
// - Clear wins; shifting always keeps working
// - Power-up leaves every switch off
// - Controller waits 500 us before writing
module sslc_device
  import sslc_pkg::*;
#(
  parameter int CHANNELS = SSLC_CHANNELS
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset_n,
  // Link pins
  sslc_link_if.device              link,
  // Switch states
  output logic [CHANNELS-1:0]      channelSwitch
);

  typedef struct packed {
    logic [2:0]          clkSync;    // Three-stage synchroniser per pin
    logic [2:0]          dataSync;
    logic [2:0]          holdSync;
    logic [2:0]          offSync;
    logic                clkLevel;   // Agreed levels
    logic                holdLevel;
    logic                offLevel;
    logic [CHANNELS-1:0] shift;
    logic [CHANNELS-1:0] latched;
    logic [CHANNELS-1:0] switches;
    logic                chain;
  } sslc_dev_state_t;

  sslc_dev_state_t state_r;
  sslc_dev_state_t state_nxt;

  // Next-state logic; a level counts once the second and third stages agree
  always_comb begin
    state_nxt = state_r;
    state_nxt.clkSync  = {state_r.clkSync[1:0], link.shiftClock};
    state_nxt.dataSync = {state_r.dataSync[1:0], link.serialIn};
    state_nxt.holdSync = {state_r.holdSync[1:0], link.latchHoldN};
    state_nxt.offSync  = {state_r.offSync[1:0], link.forceAllOff};
    if (state_r.clkSync[2] == state_r.clkSync[1]) begin
      state_nxt.clkLevel = state_r.clkSync[2];
    end
    if (state_r.holdSync[2] == state_r.holdSync[1]) begin
      state_nxt.holdLevel = state_r.holdSync[2];
    end
    if (state_r.offSync[2] == state_r.offSync[1]) begin
      state_nxt.offLevel = state_r.offSync[2];
    end
    // Shift on the rising link edge, MSB first lands at the top
    if (!state_r.clkLevel && state_r.clkSync[2] == state_r.clkSync[1]
        && state_r.clkSync[2]) begin
      // Data taken from the third stage, which the clock edge trails equally
      state_nxt.shift = {state_r.shift[CHANNELS-2:0], state_r.dataSync[2]};
    end
    // Chain pin follows the last stage, shifting never stops
    state_nxt.chain = state_r.shift[CHANNELS-1];
    // Transparent while low, frozen from the rising edge on
    if (!state_r.holdLevel) begin
      state_nxt.latched = state_r.shift;
    end else begin
      state_nxt.latched = state_r.latched;
    end
    // Clear overrides the latch; bit n drives channel n, one is on
    if (state_r.offLevel) begin
      state_nxt.switches = SSLC_SWITCH_RESET[CHANNELS-1:0];
    end else begin
      state_nxt.switches = state_r.latched;
    end
  end

  // State register; reset stands for power-up with switches off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // Hold pin idles high; start frozen so no transparent window follows reset
      state_r           <= '0;
      state_r.holdSync  <= 3'h7;
      state_r.holdLevel <= 1'h1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign channelSwitch = state_r.switches;
  assign link.chainOut = state_r.chain;

endmodule
`default_nettype wire

// ---- testbench/serial_switch_latch_control_tb.sv ----
// Bench joining the controller end and the switch device end over one link
`timescale 1ns/1ps
`default_nettype none
module serial_switch_latch_control_tb;
  import sslc_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        writeValid = 1'b0;
  logic [15:0] writeWord = 16'h0000;
  logic        clearRequest = 1'b0;
  logic        writeReady;
  logic [15:0] channelSwitch;
  int          fail_count = 0;
  int          n_tests = 0;
  sslc_link_if link ();
  // Short power-up wait keeps the run brief
  sslc_controller #(.WAIT_CYC(10)) u_sslc_controller (.clock(clock), .reset_n(reset_n),
    .writeValid(writeValid), .writeWord(writeWord), .clearRequest(clearRequest),
    .writeReady(writeReady), .link(link));
  sslc_device u_sslc_device (.clock(clock), .reset_n(reset_n), .link(link),
    .channelSwitch(channelSwitch));
  sslc_link_properties u_sslc_link_properties (.clock(clock), .reset_n(reset_n),
    .shiftClock(link.shiftClock), .serialIn(link.serialIn), .chainOut(link.chainOut),
    .latchHoldN(link.latchHoldN), .forceAllOff(link.forceAllOff),
    .channelSwitch(channelSwitch));
  always #2 clock = ~clock;
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the controller to go idle; ends on a rising edge
  task automatic wait_ready();
    int i;
    @(posedge clock);
    for (i = 0; i < 1000 && writeReady !== 1'b1; i++) @(posedge clock);
    check({15'h0000, writeReady}, 16'h0001);
  endtask
  task automatic write_word(input logic [15:0] word);
    wait_ready();
    writeValid <= 1'b1;
    writeWord  <= word;
    @(posedge clock);
    writeValid <= 1'b0;
  endtask
  task automatic settle();
    wait_ready();
    repeat (8) @(posedge clock);
    #1;
  endtask
  task automatic t_power_up();
    repeat (2) @(posedge clock);
    #1 check(channelSwitch, 16'h0000);
    $display("power-up test done");
  endtask
  // Words back to back; old state must stand while the next one shifts
  task automatic t_words();
    logic [15:0] tbl [6];
    logic [15:0] prev;
    tbl = '{16'h8000, 16'h0001, 16'hA5C3, 16'hFFFF, 16'h0000, 16'h5A3C};
    prev = 16'h0000;
    foreach (tbl[k]) begin
      write_word(tbl[k]);
      repeat (60) @(posedge clock);
      #1 check(channelSwitch, prev);
      settle();
      check(channelSwitch, tbl[k]);
      check({15'h0000, link.chainOut}, {15'h0000, tbl[k][15]});
      prev = tbl[k];
    end
    $display("word test done");
  endtask
  task automatic t_clear();
    write_word(16'hC3A5);
    settle();
    @(posedge clock);
    clearRequest <= 1'b1;
    repeat (20) @(posedge clock);
    #1 check(channelSwitch, 16'h0000);
    @(posedge clock);
    clearRequest <= 1'b0;
    repeat (40) @(posedge clock);
    #1 check(channelSwitch, 16'hC3A5);
    $display("clear test done");
  endtask
  // Clear held across a whole write: switches stay off, shifting and chain go on
  task automatic t_clear_shift();
    @(posedge clock);
    clearRequest <= 1'b1;
    write_word(16'h3C96);
    settle();
    check(channelSwitch, 16'h0000);
    check({15'h0000, link.chainOut}, 16'h0000);
    @(posedge clock);
    clearRequest <= 1'b0;
    repeat (40) @(posedge clock);
    #1 check(channelSwitch, 16'h3C96);
    $display("clear while shifting test done");
  endtask
  // Reset in mid-run must turn every switch off again
  task automatic t_rereset();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1 check(channelSwitch, 16'h0000);
    write_word(16'h1234);
    settle();
    check(channelSwitch, 16'h1234);
    $display("second reset test done");
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    t_power_up();
    t_words();
    t_clear();
    t_clear_shift();
    t_rereset();
    stop_test();
  end
  // Watchdog, far beyond the expected run of about fifteen hundred cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

// ---- testbench/sslc_link_properties.sv ----
// Concurrent checks on the serial switch link and the switch outputs
`timescale 1ns/1ps
`default_nettype none
module sslc_link_properties (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Link pins and switch states
  input  wire logic        shiftClock,
  input  wire logic        serialIn,
  input  wire logic        chainOut,
  input  wire logic        latchHoldN,
  input  wire logic        forceAllOff,
  input  wire logic [15:0] channelSwitch
);
  logic        clkPrev_r;
  logic        riseSeen_r;
  logic [15:0] history_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Own record of the bits taken on rising link edges; data is steady there
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clkPrev_r  <= 1'b0;
      riseSeen_r <= 1'b0;
      history_r  <= 16'h0000;
    end else begin
      clkPrev_r  <= shiftClock;
      riseSeen_r <= shiftClock && !clkPrev_r;
      if (shiftClock && !clkPrev_r) history_r <= {history_r[14:0], serialIn};
    end
  end
  a_chain_out_delay: assert property (
      riseSeen_r |-> ##5 chainOut == history_r[15])
    else $error("chain output is not the bit taken sixteen edges back");
  a_clear_all_off: assert property (
      forceAllOff [*8] |-> channelSwitch == 16'h0000)
    else $error("switches on while clear is high");
  a_hold_keeps_switches: assert property (
      (latchHoldN && !forceAllOff) [*8] |-> $stable(channelSwitch))
    else $error("switches moved while latch held");
  a_reset_all_off: assert property ($rose(reset_n) |-> channelSwitch == 16'h0000)
    else $error("switches on after reset");
  a_latch_pulse_width: assert property ($fell(latchHoldN) |-> !latchHoldN [*3])
    else $error("latch low pulse too short");
  a_latch_clock_quiet: assert property (!latchHoldN |-> !shiftClock)
    else $error("link clock runs during latch pulse");
  a_clock_high_time: assert property ($rose(shiftClock) |-> shiftClock [*3])
    else $error("link clock high phase too short");
  a_clock_low_time: assert property ($fell(shiftClock) |-> !shiftClock [*3])
    else $error("link clock low phase too short");
  a_clear_pulse_width: assert property (
      $rose(forceAllOff) |-> forceAllOff [*8] ##1 forceAllOff [*6])
    else $error("clear pulse too short");
endmodule
`default_nettype wire
